// [sbt_far_end.sv]
// sbt_far_end: behavioural spi controller facing the block in peripheral use
// assumes mclk from the bench; a frame starts on each rising go
`timescale 1ns/100ps
module sbt_far_end #(
  parameter int HALF = 6
) (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [1:0] mode,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  input  wire logic       miso,
  output logic            sel_n,
  output logic            sck,
  output logic            mosi,
  output logic [7:0]      rx,
  output logic            busy
);
  logic ck;
  int   i;
  int   b;
  assign sck = busy ? ck : mode[1];
  ////////////////////////////////////////
  initial begin
    sel_n = 1'b1;
    ck = 1'b0;
    mosi = 1'b0;
    rx = 8'h00;
    busy = 1'b0;
  end
  always @(posedge go) begin
    ck <= mode[1];
    busy <= 1'b1;
    sel_n <= 1'b0;
    for (i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      if (!mode[0]) mosi <= tx[b];
      repeat (HALF) @(posedge mclk);
      ck <= ~ck;
      if (mode[0]) mosi <= tx[b];
      else rx[b] = miso;
      repeat (HALF) @(posedge mclk);
      ck <= ~ck;
      if (mode[0]) rx[b] = miso;
    end
    repeat (HALF) @(posedge mclk);
    sel_n <= 1'b1;
    mosi <= ~mosi;
    busy <= 1'b0;
  end
endmodule // sbt_far_end

// [sbt_pkg.sv]
// sbt_pkg: register map, field positions and encodings of the buffered spi block
// assumes an 8-bit register port with byte-wide offsets
package sbt_pkg;
  localparam logic [2:0] ADDR_CTRL_A   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B   = 3'h1;
  localparam logic [2:0] ADDR_INT_EN   = 3'h2;
  localparam logic [2:0] ADDR_INT_FLAG = 3'h3;
  localparam logic [2:0] ADDR_DATA     = 3'h4;
  localparam logic [7:0] RST_REG       = 8'h00;
  // control_a fields
  localparam int A_ENABLE = 0;
  localparam int A_RATE_LO = 1;
  localparam int A_DOUBLE = 4;
  localparam int A_CTRL   = 5;
  localparam int A_ORDER  = 6;
  localparam logic [7:0] A_MASK = 8'h77;
  // control_b fields
  localparam int B_MODE_LO = 0;
  localparam int B_SELIGN  = 2;
  localparam int B_WAITRX  = 6;
  localparam int B_BUFON   = 7;
  localparam logic [7:0] B_MASK = 8'hC7;
  // interrupt enable and flag fields
  localparam int F_OVR    = 0;
  localparam int F_BASIC  = 0;
  localparam int F_SEL    = 4;
  localparam int F_TXE    = 5;
  localparam int F_TXD    = 6;
  localparam int F_RXD    = 7;
  localparam logic [7:0] IE_MASK = 8'hF1;
  localparam logic [7:0] F_MASK  = 8'hF1;
  localparam int BYTE_BITS = 8;
  // half-period of sck in mclk cycles per rate code, before doubling
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  typedef enum logic [1:0] {SBT_IDLE, SBT_LEAD, SBT_TRAIL} sbt_state_t;
endpackage

// [sbt_spi.sv]
// sbt_spi: buffered spi controller/peripheral with register port
// assumes pins already synchronous to mclk; sck input half-periods over two mclk
//
// Functional notes
// RULE1: buffer_mode_on enables buffers and extra flags
// RULE2: buffered data writes go to transmit buffer
// RULE3: wait_receive_sel clear sends dummy first byte
// RULE4: transfer end moves buffer into shift register; as controller the block moves it at transfer start instead
// RULE5: write while buffer full is discarded
// RULE6: buffer write clears, buffer move sets tx_empty_flag
// RULE7: rx_done_flag one cycle after tx_empty_flag
// RULE8: tx_done_flag one cycle after rx_done_flag, all sent
// RULE9: wait_receive_sel with select high loads shifter
// RULE10: flag timing same for both wait modes
// RULE11: mode picks launch and capture edges
// RULE12: leading edge is first of bit period
// RULE13: one interrupt line, four buffered sources
// RULE14: flags set always; request while flag and enable
// RULE15: run in idle sleep, deep sleep aborts
// RULE16: bit_order_sel zero msb first, one lsb
// RULE17: select low demotes controller, sets flag
// RULE18: sck_double doubles controller sck rate
// RULE19: mode encoding of polarity and sample edge
// RULE20: rate_divider divides by 4,16,64,128
// RULE21: wait_receive_sel ignored as controller
// RULE22: unused bits read zero, writes ignored
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module sbt_spi
  import sbt_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       deep_sleep,
  input  wire logic       sel_in,
  input  wire logic       sel_is_input,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  output logic            irq
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_a_ff, ctrl_b_ff, int_en_ff, flags_ff, shift_ff, txbuf_ff;
  logic [7:0] rx0_ff, rx1_ff;
  logic [1:0] rx_cnt_ff;
  logic       txbuf_full_ff, rxd_pend_ff, txd_pend_ff;
  logic [6:0] div_ff;
  logic [2:0] bit_ff;
  logic       sck_ff, sck_prev_ff, sel_prev_ff, all_sent_q, shift_out_ff;
  logic       oe_ctrl_ff, miso_oe_ff;
  sbt_state_t st_ff;
  logic       irq_ff;
  logic [7:0] rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  wire        en       = ctrl_a_ff[A_ENABLE];
  wire        is_ctrl  = ctrl_a_ff[A_CTRL];
  wire        lsb_1st  = ctrl_a_ff[A_ORDER];                              // RULE16
  wire [1:0]  rate     = ctrl_a_ff[A_RATE_LO +: 2];
  wire [1:0]  mode     = ctrl_b_ff[B_MODE_LO +: 2];
  wire        cpol     = mode[1];                                         // RULE19
  wire        cpha     = mode[0];                                         // RULE19
  wire        bufon    = ctrl_b_ff[B_BUFON];                              // RULE1
  wire        waitrx   = ctrl_b_ff[B_WAITRX] & ~is_ctrl;                  // RULE21
  wire        wr_data  = reg_wr & (reg_addr == ADDR_DATA);
  wire        rd_data  = reg_rd & (reg_addr == ADDR_DATA);
  wire        wr_flag  = reg_wr & (reg_addr == ADDR_INT_FLAG);
  wire        busy     = (st_ff != SBT_IDLE);

  function automatic logic [6:0] half_of(input logic [1:0] r, input logic dbl);
    logic [6:0] h;
    h = 7'h00;
    unique case (r)
      2'h0: h = HALF_DIV4;
      2'h1: h = HALF_DIV16;
      2'h2: h = HALF_DIV64;
      2'h3: h = HALF_DIV128;
    endcase
    half_of = dbl ? (h >> 1) : h;
  endfunction
  wire [6:0]  half     = half_of(rate, ctrl_a_ff[A_DOUBLE]);              // RULE18 RULE20

  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[BYTE_BITS-1];
  endfunction

  // select low as input while controller demotes the block
  wire        demote   = en & is_ctrl & sel_is_input & ~sel_in
                         & ~ctrl_b_ff[B_SELIGN];                          // RULE17
  wire        sel_act  = ~sel_in;
  wire        stop     = deep_sleep | ~en | (~is_ctrl & sel_in) | demote; // RULE15

  // edge events on the serial clock
  wire        c_tick   = is_ctrl & busy & (div_ff == 7'h01);
  wire        p_rise   = ~is_ctrl & sel_act & sck_in & ~sck_prev_ff;
  wire        p_fall   = ~is_ctrl & sel_act & ~sck_in & sck_prev_ff;
  wire        p_edge   = p_rise | p_fall;
  wire        lead_cur = (st_ff == SBT_IDLE || st_ff == SBT_TRAIL);
  wire        p_lead   = cpol ? p_fall : p_rise;                          // RULE12
  wire        edge_ev  = is_ctrl ? c_tick : p_edge;
  wire        is_lead  = is_ctrl ? lead_cur : p_lead;
  wire        samp_ev  = edge_ev & (is_lead ^ cpha);                      // RULE11
  wire        last     = (bit_ff == 3'h7);
  wire        done     = ~stop & edge_ev & ~is_lead & last;
  wire        c_start  = is_ctrl & en & ~busy & ~stop & txbuf_full_ff;
  wire        p_start  = ~is_ctrl & ~stop & ~busy & p_edge;

  // shift data in/out
  wire        in_bit   = is_ctrl ? miso_in : mosi_in;
  wire [7:0]  shifted  = lsb_1st ? {in_bit, shift_ff[7:1]} : {shift_ff[6:0], in_bit};
  wire        direct   = bufon & waitrx & sel_in & ~busy & wr_data & ~txbuf_full_ff; // RULE9
  wire        buf_wr   = wr_data & ~txbuf_full_ff & ~direct;             // RULE2 RULE5
  // controller loads its byte at start, peripheral at the end of a transfer
  wire        move     = txbuf_full_ff & (is_ctrl ? c_start : done);      // RULE4

  //////////////////////////////////////////////////////////////////////////////
  // serial engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= SBT_IDLE;
      bit_ff      <= 3'h0;
      div_ff      <= 7'h00;
      sck_ff      <= 1'b0;
      sck_prev_ff <= 1'b0;
      shift_ff    <= RST_REG;
    end else begin
      sck_prev_ff <= sck_in;
      if (stop || done) begin                                             // RULE15
        st_ff  <= SBT_IDLE;
        bit_ff <= 3'h0;
        sck_ff <= cpol;
      end else if (c_start || p_start) begin
        st_ff  <= p_start && p_lead ? SBT_LEAD : (p_start ? SBT_TRAIL : SBT_IDLE);
        div_ff <= half;
        if (c_start)
          st_ff <= SBT_IDLE;
        if (c_start)
          st_ff <= SBT_TRAIL;
      end else if (edge_ev) begin
        st_ff  <= is_lead ? SBT_LEAD : SBT_TRAIL;
        div_ff <= half;
        if (is_ctrl)
          sck_ff <= ~sck_ff;
        if (!is_lead)
          bit_ff <= bit_ff + 3'h1;
      end else if (is_ctrl && busy) begin
        div_ff <= div_ff - 7'h01;
      end else if (!busy) begin
        sck_ff <= cpol;
      end
      if (move)
        shift_ff <= txbuf_ff;                                             // RULE4
      else if (direct)
        shift_ff <= reg_wdata;                                            // RULE9
      else if (!bufon && wr_data && !busy)
        shift_ff <= reg_wdata;
      else if (samp_ev && !stop)
        shift_ff <= shifted;                                              // RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit buffer, receive fifo, flags
  // with late sampling the last bit arrives on the ending edge itself
  wire [7:0]  rx_byte  = cpha ? shifted : shift_ff;
  wire        rx_push  = done;
  wire        rx_pop   = rd_data & (rx_cnt_ff != 2'h0);
  wire        all_sent = done & ~txbuf_full_ff;
  wire        set_sel  = bufon & ~is_ctrl & sel_prev_ff & ~sel_in;
  wire [7:0]  clr      = wr_flag ? (reg_wdata & F_MASK) : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_ff      <= RST_REG;
      txbuf_full_ff <= 1'b0;
      rx0_ff        <= RST_REG;
      rx1_ff        <= RST_REG;
      rx_cnt_ff     <= 2'h0;
      rxd_pend_ff   <= 1'b0;
      txd_pend_ff   <= 1'b0;
      flags_ff      <= RST_REG;
      sel_prev_ff   <= 1'b1;
    end else begin
      sel_prev_ff <= sel_in;
      if (buf_wr && bufon)
        txbuf_ff <= reg_wdata;                                            // RULE2
      // holding the first byte back produces the dummy transfer
      txbuf_full_ff <= bufon & ((txbuf_full_ff & ~move) | buf_wr);        // RULE3 RULE6
      if (rx_push && rx_pop) begin
        rx0_ff <= (rx_cnt_ff == 2'h2) ? rx1_ff : rx_byte;
        rx1_ff <= rx_byte;
      end else if (rx_push) begin
        if (rx_cnt_ff == 2'h0)
          rx0_ff <= rx_byte;
        else
          rx1_ff <= rx_byte;
        if (rx_cnt_ff != 2'h2)
          rx_cnt_ff <= rx_cnt_ff + 2'h1;
      end else if (rx_pop) begin
        rx0_ff    <= rx1_ff;
        rx_cnt_ff <= rx_cnt_ff - 2'h1;
      end
      rxd_pend_ff <= done;                                                // RULE7 RULE10
      txd_pend_ff <= rxd_pend_ff & ~txbuf_full_ff;                         // RULE8
      // hardware set wins over a software clear
      flags_ff[F_TXE] <= bufon & ((flags_ff[F_TXE] & ~buf_wr) | move);    // RULE6
      flags_ff[F_RXD] <= (bufon ? ((flags_ff[F_RXD] & ~clr[F_RXD] & ~(rx_pop
                         && rx_cnt_ff == 2'h1)) | rxd_pend_ff)
                         : ((flags_ff[F_RXD] & ~clr[F_RXD]) | done))
                         | demote;                                        // RULE7 RULE17
      flags_ff[F_TXD] <= (flags_ff[F_TXD] & ~clr[F_TXD])
                         | (bufon & txd_pend_ff & all_sent_q);            // RULE8
      flags_ff[F_SEL] <= (flags_ff[F_SEL] & ~clr[F_SEL]) | set_sel;        // RULE14
      flags_ff[F_OVR] <= (flags_ff[F_OVR] & ~clr[F_OVR])
                         | (bufon & rx_push & ~rx_pop & (rx_cnt_ff == 2'h2));
      flags_ff[3:1]   <= 3'h0;                                            // RULE22
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      all_sent_q <= 1'b0;
    else
      all_sent_q <= all_sent | (all_sent_q & ~txd_pend_ff);
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port and pins
  wire [7:0]  data_rd  = bufon ? rx0_ff : shift_ff;
  wire [7:0]  sel_rd   = (reg_addr == ADDR_CTRL_A)   ? ctrl_a_ff :
                         (reg_addr == ADDR_CTRL_B)   ? ctrl_b_ff :
                         (reg_addr == ADDR_INT_EN)   ? int_en_ff :
                         (reg_addr == ADDR_INT_FLAG) ? flags_ff  :
                         (reg_addr == ADDR_DATA)     ? data_rd   : 8'h00; // RULE22
  wire [7:0]  pend     = flags_ff & int_en_ff;
  wire        irq_nxt  = bufon ? (|pend[7:4])                             // RULE13 RULE14
                               : (flags_ff[F_RXD] & int_en_ff[F_BASIC]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_ff <= RST_REG;
      ctrl_b_ff <= RST_REG;
      int_en_ff <= RST_REG;
      rdata_ff  <= RST_REG;
      irq_ff    <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL_A)
        ctrl_a_ff <= reg_wdata & A_MASK;                                  // RULE22
      else if (demote)
        ctrl_a_ff[A_CTRL] <= 1'b0;                                        // RULE17
      if (reg_wr && reg_addr == ADDR_CTRL_B)
        ctrl_b_ff <= reg_wdata & B_MASK;                                  // RULE1
      if (reg_wr && reg_addr == ADDR_INT_EN)
        int_en_ff <= reg_wdata & IE_MASK;
      rdata_ff <= reg_rd ? sel_rd : 8'h00;
      irq_ff   <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;
  assign sck_out   = sck_ff;
  assign sck_oe    = oe_ctrl_ff;
  assign mosi_out  = shift_out_ff;
  assign mosi_oe   = oe_ctrl_ff;
  assign miso_out  = shift_out_ff;
  assign miso_oe   = miso_oe_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_ff <= 1'b0;
      oe_ctrl_ff   <= 1'b0;
      miso_oe_ff   <= 1'b0;
    end else begin
      shift_out_ff <= out_bit(move ? txbuf_ff : shift_ff, lsb_1st);       // RULE16
      oe_ctrl_ff   <= en & is_ctrl;
      miso_oe_ff   <= en & ~is_ctrl & sel_act;
    end
  end
endmodule // sbt_spi

// [sbt_spi_properties.sv]
// sbt_spi_properties: port-level assertions for the buffered spi block
// assumes the bind below attaches it to every sbt_spi instance
`timescale 1ns/100ps
module sbt_spi_properties
  import sbt_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       deep_sleep,
  input wire logic       sel_in,
  input wire logic       sel_is_input,
  input wire logic       sck_in,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       miso_out,
  input wire logic       miso_oe,
  input wire logic       irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  sequence s_wr_b;
    reg_wr && reg_addr == ADDR_CTRL_B;
  endsequence
  sequence s_rd_b;
    reg_rd && reg_addr == ADDR_CTRL_B;
  endsequence
  sequence s_en_off;
    reg_wr && reg_addr == ADDR_INT_EN && reg_wdata == 8'h00;
  endsequence
  AST_UNMAPPED: assert property (reg_rd && reg_addr > ADDR_DATA |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  AST_MASK_B: assert property (
    s_wr_b ##2 s_rd_b |=> reg_rdata == ($past(reg_wdata, 3) & B_MASK))
    else $error("control_b readback wrong");
  AST_IRQ_OFF: assert property (s_en_off ##1 !(reg_wr && reg_addr == ADDR_INT_EN) |=> !irq)
    else $error("irq with all enables off");
  AST_IRQ_HOLD: assert property ($fell(irq) |->
    $past(reg_wr) || $past(reg_rd) || $past(reg_wr, 2) || $past(reg_rd, 2) || $past(reg_wr, 3)
    || $past(reg_rd, 3))
    else $error("irq dropped without software");
  AST_SLEEP: assert property (deep_sleep [*3] |=> $stable(sck_out))
    else $error("sck moves in deep sleep");
  AST_DEMOTE: assert property ((sel_is_input && !sel_in) [*4] |-> !sck_oe)
    else $error("still driving sck with select low");
  AST_MISO_STILL: assert property (
    (miso_oe && $stable(sck_in) && $stable(sel_in)) [*4] |-> $stable(miso_out))
    else $error("miso moved without sck edge");
endmodule // sbt_spi_properties

bind sbt_spi sbt_spi_properties i_sbt_spi_properties (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .deep_sleep(deep_sleep), .sel_in(sel_in),
  .sel_is_input(sel_is_input), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
  .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq));

// [sbt_spi_tb.sv]
// sbt_spi_tb: self-checking bench for the buffered spi block
// assumes sbt_far_end as the far side and the bound property checker
`timescale 1ns/100ps
module sbt_spi_tb
  import sbt_pkg::*;
;
  logic       mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic       deep_sleep = 1'b0, sel_is_input = 1'b0, sel_drop = 1'b0, far_lsb = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [1:0] far_mode = 2'h0;
  logic [7:0] reg_wdata = 8'h00, far_tx = 8'h00, far_rx, reg_rdata, r;
  logic [7:0] v [8];
  logic [7:0] masks [3] = '{A_MASK, B_MASK, IE_MASK};
  logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
  logic       far_sck, far_mosi, far_sel_n, far_busy;
  int         seed = 32'h66C4, failures = 0, comparisons = 0, cycles = 0, p;
  sbt_spi i_sbt_spi (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .deep_sleep(deep_sleep),
    .sel_in(far_sel_n & ~sel_drop), .sel_is_input(sel_is_input),
    .sck_in(sck_oe ? sck_out : far_sck), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_oe ? mosi_out : far_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(far_mosi), .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq));
  sbt_far_end i_sbt_far_end (.mclk(mclk), .go(go), .mode(far_mode), .lsb(far_lsb), .tx(far_tx),
    .miso(miso_oe ? miso_out : ~miso_out), .sel_n(far_sel_n), .sck(far_sck), .mosi(far_mosi),
    .rx(far_rx), .busy(far_busy));
  always #20 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic xfer(input logic [7:0] t);
    int n;
    @(posedge mclk);
    far_tx <= t;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; far_busy === 1'b1 && n < 400; n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic period(output int q);
    int n;
    for (n = 0; sck_out !== 1'b1 && n < 300; n++) @(posedge mclk);
    for (q = 0; sck_out === 1'b1 && q < 300; q++) @(posedge mclk);
    for (; sck_out !== 1'b1 && q < 300; q++) @(posedge mclk);
  endtask
  function automatic logic [7:0] per(input int c, input logic k);
    return ((c == 0) ? 8'h04 : (c == 1) ? 8'h10 : (c == 2) ? 8'h40 : 8'h80) >> k;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    foreach (v[i]) v[i] = 8'($random(seed));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      if (a != 4) rd(3'(a), 8'hFF, 8'h00);
    end
    for (int a = 0; a < 3; a++) begin
      wr(3'(a), 8'hFF);
      rd(3'(a), 8'hFF, masks[a]);
      wr(3'(a), 8'h00);
    end
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'hFF, 8'h00);
    // buffered peripheral, dummy byte first, one write lost
    wr(ADDR_CTRL_B, 8'h80);
    wr(ADDR_CTRL_A, 8'h01);
    xfer(v[0]);
    rd(ADDR_DATA, 8'hFF, v[0]);
    wr(ADDR_DATA, v[1]);
    rd(ADDR_INT_FLAG, 8'h20, 8'h00);
    wr(ADDR_DATA, v[2]);
    xfer(v[3]);
    chk(far_rx, v[0]);
    rd(ADDR_INT_FLAG, 8'hA0, 8'hA0);
    rd(ADDR_DATA, 8'hFF, v[3]);
    wr(ADDR_DATA, v[4]);
    xfer(v[5]);
    chk(far_rx, v[1]);
    wr(ADDR_INT_FLAG, 8'h40);
    xfer(v[6]);
    chk(far_rx, v[4]);
    rd(ADDR_INT_FLAG, 8'h40, 8'h40);
    rd(ADDR_DATA, 8'hFF, v[5]);
    rd(ADDR_DATA, 8'hFF, v[6]);
    // every mode and bit order, write with select high goes to the shifter
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 2; o++) begin
        wr(ADDR_CTRL_A, 8'h01 | 8'(o << 6));
        wr(ADDR_CTRL_B, 8'hC0 | 8'(m));
        far_mode <= 2'(m);
        far_lsb <= o[0];
        r = 8'($random(seed));
        wr(ADDR_DATA, r ^ 8'hA5);
        xfer(r);
        chk(far_rx, r ^ 8'hA5);
        rd(ADDR_DATA, 8'hFF, r);
      end
    end
    wr(ADDR_INT_FLAG, 8'hFF);
    wr(ADDR_INT_EN, 8'h80);
    xfer(v[7]);
    irq_is(1'b1);
    wr(ADDR_INT_FLAG, 8'h80);
    irq_is(1'b0);
    rd(ADDR_DATA, 8'hFF, v[7]);
    wr(ADDR_INT_EN, 8'h20);
    irq_is(1'b1);
    wr(ADDR_INT_EN, 8'h00);
    irq_is(1'b0);
    // controller: abort in deep sleep, then sck rates
    sel_is_input <= 1'b1;
    wr(ADDR_CTRL_B, 8'hC0);
    wr(ADDR_CTRL_A, 8'h23);
    wr(ADDR_INT_FLAG, 8'hFF);
    wr(ADDR_DATA, 8'h5A);
    repeat (30) @(posedge mclk);
    deep_sleep <= 1'b1;
    repeat (10) @(posedge mclk);
    deep_sleep <= 1'b0;
    repeat (200) @(posedge mclk);
    rd(ADDR_INT_FLAG, 8'h80, 8'h00);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        wr(ADDR_CTRL_A, 8'h21 | 8'(k << 4) | 8'(c << 1));
        wr(ADDR_DATA, 8'($random(seed)));
        period(p);
        chk(8'(p), per(c, k[0]));
        repeat (8 * p) @(posedge mclk);
      end
    end
    wr(ADDR_INT_FLAG, 8'hFF);
    sel_drop <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(ADDR_CTRL_A, 8'hFF, 8'h17);
    rd(ADDR_INT_FLAG, 8'h80, 8'h80);
    tally_and_finish();
  end
endmodule // sbt_spi_tb
